// ===== hdl/pds_pkg.sv
// Shared constants and carriers for the program download sequencer.
// Assumes a 20 MHz system clock and a framing layer that builds and checks
// the serial frames, including the frame check byte.
package pds_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MFR     = 8'h08;
  localparam logic [7:0] OFS_PID_LO  = 8'h0C;
  localparam logic [7:0] OFS_PID_HI  = 8'h10;
  localparam logic [7:0] OFS_ENV     = 8'h14;
  localparam logic [7:0] OFS_MAXSIZE = 8'h18;
  localparam logic [7:0] OFS_SPEED   = 8'h1C;
  localparam int CTRL_START   = 0;
  localparam int CTRL_P2P     = 1;
  localparam int CTRL_RETAIN  = 2;
  localparam int CTRL_SPD_BAD = 3;
  localparam logic [7:0]  ENV_INTERP    = 8'h00;
  localparam logic [15:0] MAXSIZE_RESET = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ==========================================================================
  // Frame fields
  localparam logic [7:0]  FRAME_START     = 8'h02;
  localparam logic [15:0] FRAME_TYPE      = 16'h0100;
  localparam logic [7:0]  CMD_DL_REQ      = 8'h00;
  localparam logic [7:0]  CMD_VALIDATE    = 8'h02;
  localparam logic [7:0]  CMD_DONE_NOTIFY = 8'h01;
  localparam logic [7:0]  CMD_DONE_RSP    = 8'h81;
  localparam logic [15:0] LEN_DONE        = 16'h0001;
  localparam logic [15:0] LEN_DL_REQ      = 16'h0002;
  localparam logic [7:0]  RESULT_FAIL     = 8'h00;
  localparam logic [7:0]  RESULT_OK       = 8'h01;
  localparam logic [7:0]  VALID_CUR_SPEED = 8'h01;
  localparam logic [15:0] SEQ_SWINFO      = 16'h0000;
  localparam logic [15:0] SEQ_ENVID       = 16'h0001;
  localparam logic [15:0] SEQ_DATA0       = 16'h0002;
  localparam logic [1:0]  RETRY_MAX       = 2'h3;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ    = 20_000_000;
  localparam int TRANS_MS  = 500;
  localparam int WAIT_MS   = 300;
  localparam int TRANS_CYC = TRANS_MS * (CLK_HZ / 1000);
  localparam int WAIT_CYC  = WAIT_MS * (CLK_HZ / 1000);
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  start;
    logic [15:0] ftype;
    logic [7:0]  cmd;
    logic [7:0]  fseq;
    logic [15:0] len;
    logic [15:0] seq;
    logic [7:0]  result;
  } req_frame_type;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  fseq;
    logic        check_ok;
    logic [15:0] seq;
    logic [23:0] mfr;
    logic [47:0] pid;
    logic [15:0] split_cnt;
    logic [7:0]  env_id;
    logic [7:0]  data_len;
  } rsp_frame_type;
endpackage : pds_pkg

// ===== hdl/program_download_sequencer.sv
// Program download sequencer with an AXI4-Lite register slave.
// Assumes a framing layer that serialises req_o and reports parsed
// responses on rsp_i, one pulse of rsp_valid_i per received frame.
// Function
// - Compare received environment with own environment
// - Identifier 0x00 is interpreter; others reserved
// - Peer mode with retention waits transition first
// - Transition period lasts at least 500 ms
// - Requests go at the detected link speed
// - Unusable speed: notify, keep current speed
// - New software and matching environment fetch from 2
// - Same software: skip, send success completion
// - Wait 300 ms per response before failing
// - Error indicator output shows download errors
// - Failed reception retransmits the same request
// - Failure after third retransmission declares error
// - Wrong frame number: nonzero and different
// - Oversize data is discarded and flagged
// - Wrong maker or environment discards and flags
// - Completion notification answered by completion response
module program_download_sequencer
  import pds_pkg::*;
#(
  parameter int TRANS_CYCLES = TRANS_CYC,
  parameter int WAIT_CYCLES  = WAIT_CYC
)(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [7:0]    s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  input  wire logic [7:0]    s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  output req_frame_type      req_o,
  output logic               req_valid_o,
  input  wire logic          req_ready_i,
  input  wire rsp_frame_type rsp_i,
  input  wire logic          rsp_valid_i,
  output logic [7:0]         link_speed_o,
  output logic               error_led_o,
  output logic               discard_o,
  output logic               done_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_TRANS, ST_VALID, ST_SEND, ST_WAIT, ST_DONE_TX, ST_DONE_WAIT
  } state_type;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction : merge

  function automatic logic [7:0] next_fseq(input logic [7:0] f);
    return (f == 8'hFF) ? 8'h01 : f + 8'h01;
  endfunction : next_fseq

  localparam logic [23:0] TRANS_LOAD = 24'(TRANS_CYCLES - 1);
  localparam logic [23:0] WAIT_LOAD  = 24'(WAIT_CYCLES - 1);

  // ==========================================================================
  // Register slave
  logic        aw_held_reg, w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [3:0]  ctrl_reg;
  logic [23:0] mfr_reg;
  logic [31:0] pid_lo_reg;
  logic [15:0] pid_hi_reg;
  logic [7:0]  env_reg;
  logic [15:0] maxsize_reg;
  logic [7:0]  speed_reg;

  wire         wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire         rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire [31:0]  wr_ctrl = merge(32'h0, w_data_reg, w_strb_reg);
  wire [31:0]  mfr_merged = merge({8'h00, mfr_reg}, w_data_reg, w_strb_reg);
  wire         start_hit = wr_fire && (aw_addr_reg == OFS_CTRL)
                           && wr_ctrl[CTRL_START];
  wire         wr_known = (aw_addr_reg == OFS_CTRL)
                          || (aw_addr_reg == OFS_MFR)
                          || (aw_addr_reg == OFS_PID_LO)
                          || (aw_addr_reg == OFS_PID_HI)
                          || (aw_addr_reg == OFS_ENV)
                          || (aw_addr_reg == OFS_MAXSIZE)
                          || (aw_addr_reg == OFS_SPEED);
  logic [31:0] rd_value;
  logic        rd_known;
  logic [31:0] status_word;

  assign s_axi_awready_o = !aw_held_reg;
  assign s_axi_wready_o  = !w_held_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;

  always_comb
  begin
    rd_known = 1'b1;
    if (s_axi_araddr_i == OFS_CTRL)
      rd_value = {28'h0, ctrl_reg};
    else if (s_axi_araddr_i == OFS_STATUS)
      rd_value = status_word;
    else if (s_axi_araddr_i == OFS_MFR)
      rd_value = {8'h00, mfr_reg};
    else if (s_axi_araddr_i == OFS_PID_LO)
      rd_value = pid_lo_reg;
    else if (s_axi_araddr_i == OFS_PID_HI)
      rd_value = {16'h0000, pid_hi_reg};
    else if (s_axi_araddr_i == OFS_ENV)
      rd_value = {24'h0, env_reg};
    else if (s_axi_araddr_i == OFS_MAXSIZE)
      rd_value = {16'h0000, maxsize_reg};
    else if (s_axi_araddr_i == OFS_SPEED)
      rd_value = {24'h0, speed_reg};
    else
    begin
      rd_value = 32'h0;
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
      ctrl_reg    <= 4'h0;
      mfr_reg     <= 24'h0;
      pid_lo_reg  <= 32'h0;
      pid_hi_reg  <= 16'h0000;
      env_reg     <= ENV_INTERP;
      maxsize_reg <= MAXSIZE_RESET;
      speed_reg   <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_reg == OFS_CTRL)
          ctrl_reg <= {wr_ctrl[CTRL_SPD_BAD:CTRL_P2P], 1'b0};
        else if (aw_addr_reg == OFS_MFR)
          mfr_reg <= mfr_merged[23:0];
        else if (aw_addr_reg == OFS_PID_LO)
          pid_lo_reg <= merge(pid_lo_reg, w_data_reg, w_strb_reg);
        else if (aw_addr_reg == OFS_PID_HI)
          pid_hi_reg <= wr_ctrl[15:0] | (pid_hi_reg & ~{{8{w_strb_reg[1]}},
                                                       {8{w_strb_reg[0]}}});
        else if (aw_addr_reg == OFS_ENV && w_strb_reg[0])
          env_reg <= w_data_reg[7:0];
        else if (aw_addr_reg == OFS_MAXSIZE)
          maxsize_reg <= wr_ctrl[15:0]
                         | (maxsize_reg & ~{{8{w_strb_reg[1]}},
                                            {8{w_strb_reg[0]}}});
        else if (aw_addr_reg == OFS_SPEED && w_strb_reg[0])
          speed_reg <= w_data_reg[7:0];
      end
      if (bvalid_reg && s_axi_bready_i)
        bvalid_reg <= 1'b0;
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_value;
        rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready_i)
        rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Download sequencer
  state_type   state_reg, state_next;
  logic [23:0] timer_reg;
  logic [15:0] seq_reg, split_reg, total_reg;
  logic [1:0]  retry_reg;
  logic [7:0]  fseq_reg, result_reg;
  logic        sw_same_reg, err_reg, discard_reg, done_reg, busy_reg;

  wire rsp_in   = (state_reg == ST_WAIT) && rsp_valid_i;
  wire fseq_bad = (rsp_i.fseq != 8'h00) && (rsp_i.fseq != fseq_reg);
  wire rx_fail  = (rsp_in && (!rsp_i.check_ok || fseq_bad))
                  || ((state_reg == ST_WAIT) && !rsp_valid_i
                      && timer_reg == 24'h0);
  wire rx_good  = rsp_in && !rx_fail;
  wire mfr_bad  = rsp_i.mfr != mfr_reg;
  wire env_bad  = rsp_i.env_id != env_reg;
  wire sw_same  = !mfr_bad && (rsp_i.pid == {pid_hi_reg, pid_lo_reg});
  // One spare bit so a running sum near the limit cannot wrap past it
  wire [16:0] total_sum = {1'b0, total_reg} + {9'h000, rsp_i.data_len};
  wire too_big  = total_sum > {1'b0, maxsize_reg};
  wire data_seq = seq_reg >= SEQ_DATA0;
  wire last_seq = seq_reg == split_reg + 16'h0001;
  // Any detected content error ends the transfer at once
  wire content_err = rx_good
                     && (((seq_reg == SEQ_SWINFO) && mfr_bad)
                         || ((seq_reg == SEQ_ENVID) && env_bad)
                         || (data_seq && too_big));
  wire retry_out   = rx_fail && (retry_reg == RETRY_MAX);
  wire fail_now    = content_err || retry_out;
  wire finish_ok   = rx_good && !content_err
                     && (((seq_reg == SEQ_ENVID) && sw_same_reg)
                         || (data_seq && last_seq));
  wire after_trans = ctrl_reg[CTRL_SPD_BAD];
  // Decided from the starting write itself, as the speed bit is
  wire need_trans  = wr_ctrl[CTRL_P2P] && wr_ctrl[CTRL_RETAIN];
  wire req_fire    = req_valid_o && req_ready_i;
  wire done_ack    = (state_reg == ST_DONE_WAIT)
                     && ((rsp_valid_i && rsp_i.cmd == CMD_DONE_RSP)
                         || timer_reg == 24'h0);

  assign status_word = {16'h0, result_reg, 1'b0, state_reg, retry_reg,
                        err_reg, busy_reg};

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_hit)
          state_next = need_trans ? ST_TRANS
                       : (wr_ctrl[CTRL_SPD_BAD] ? ST_VALID : ST_SEND);
      ST_TRANS:
        if (timer_reg == 24'h0)
          state_next = after_trans ? ST_VALID : ST_SEND;
      ST_VALID:
        if (req_fire)
          state_next = ST_SEND;
      ST_SEND:
        if (req_fire)
          state_next = ST_WAIT;
      ST_WAIT:
        if (fail_now || finish_ok)
          state_next = ST_DONE_TX;
        else if (rx_good || rx_fail)
          state_next = ST_SEND;
      ST_DONE_TX:
        if (req_fire)
          state_next = ST_DONE_WAIT;
      ST_DONE_WAIT:
        if (done_ack)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Frame builder; the completion frame fixes start, type, code and length
  always_comb
  begin
    req_o        = '0;
    req_o.start  = FRAME_START;
    req_o.ftype  = FRAME_TYPE;
    req_o.fseq   = fseq_reg;
    req_valid_o  = 1'b0;
    if (state_reg == ST_VALID)
    begin
      req_valid_o  = 1'b1;
      req_o.cmd    = CMD_VALIDATE;
      req_o.len    = LEN_DONE;
      req_o.result = VALID_CUR_SPEED;
    end
    else if (state_reg == ST_SEND)
    begin
      req_valid_o = 1'b1;
      req_o.cmd   = CMD_DL_REQ;
      req_o.len   = LEN_DL_REQ;
      req_o.seq   = seq_reg;
    end
    else if (state_reg == ST_DONE_TX)
    begin
      req_valid_o  = 1'b1;
      req_o.cmd    = CMD_DONE_NOTIFY;
      req_o.len    = LEN_DONE;
      req_o.result = result_reg;
    end
  end

  assign link_speed_o = speed_reg;
  assign error_led_o  = err_reg;
  assign discard_o    = discard_reg;
  assign done_o       = done_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg   <= ST_IDLE;
      timer_reg   <= 24'h0;
      seq_reg     <= SEQ_SWINFO;
      split_reg   <= 16'h0000;
      total_reg   <= 16'h0000;
      retry_reg   <= 2'h0;
      fseq_reg    <= 8'h01;
      result_reg  <= RESULT_FAIL;
      sw_same_reg <= 1'b0;
      err_reg     <= 1'b0;
      discard_reg <= 1'b0;
      done_reg    <= 1'b0;
      busy_reg    <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      discard_reg <= content_err;
      done_reg    <= done_ack;
      if (timer_reg != 24'h0)
        timer_reg <= timer_reg - 24'h1;
      if (start_hit && state_reg == ST_IDLE)
      begin
        timer_reg <= TRANS_LOAD;
        seq_reg   <= SEQ_SWINFO;
        total_reg <= 16'h0000;
        retry_reg <= 2'h0;
        err_reg   <= 1'b0;
        busy_reg  <= 1'b1;
      end
      if (req_fire)
        timer_reg <= WAIT_LOAD;
      if (req_fire && state_reg != ST_SEND)
        fseq_reg <= next_fseq(fseq_reg);
      if (rx_fail && !retry_out)
        retry_reg <= retry_reg + 2'h1;
      if (fail_now)
      begin
        err_reg    <= 1'b1;
        result_reg <= RESULT_FAIL;
      end
      else if (finish_ok)
        result_reg <= RESULT_OK;
      else if (rx_good)
      begin
        retry_reg <= 2'h0;
        fseq_reg  <= next_fseq(fseq_reg);
        if (seq_reg == SEQ_SWINFO)
        begin
          sw_same_reg <= sw_same;
          split_reg   <= rsp_i.split_cnt;
        end
        if (data_seq)
          total_reg <= total_sum[15:0];
        seq_reg <= seq_reg + 16'h0001;
      end
      if (done_ack)
        busy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  a_trans_to_req: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_TRANS && timer_reg == 24'h0 && !after_trans
    |=> req_valid_o && req_o.seq == SEQ_SWINFO)
    else $error("download request not sent after transition");
  a_trans_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_TRANS && timer_reg != 24'h0 |=> !req_valid_o)
    else $error("request sent during transition period");
  a_speed_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_WAIT |=> $stable(link_speed_o) || !busy_reg)
    else $error("link speed changed");
  a_valid_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_VALID && req_fire |=> state_reg == ST_SEND
    && req_o.seq == seq_reg)
    else $error("validation not followed by request");
  a_skip_success: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_good && seq_reg == SEQ_ENVID && !env_bad && sw_same_reg
    |=> state_reg == ST_DONE_TX && req_o.result == RESULT_OK)
    else $error("identical software not skipped");
  a_retry_same: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_fail && !retry_out |=> req_valid_o && $stable(seq_reg)
    && $stable(fseq_reg) && retry_reg == $past(retry_reg) + 2'h1)
    else $error("failed reception not retransmitted");
  a_retry_error: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_fail && retry_reg == RETRY_MAX
    |=> error_led_o ##0 req_o.result == RESULT_FAIL)
    else $error("fourth failure not flagged");
  a_frame_check: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rsp_in && rsp_i.check_ok && rsp_i.fseq == 8'h00 |-> !rx_fail)
    else $error("frame number zero refused");
  a_size_discard: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_good && data_seq && too_big |=> discard_o && error_led_o
    && $stable(total_reg))
    else $error("oversize data accepted");
  a_env_error: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_good && seq_reg == SEQ_ENVID && env_bad
    |=> error_led_o ##1 !(state_reg == ST_SEND))
    else $error("environment mismatch not flagged");
  a_wait_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_WAIT |-> timer_reg <= WAIT_LOAD)
    else $error("response wait exceeds limit");
endmodule : program_download_sequencer

// ===== sim/equip_model.sv
// Equipment model: takes one frame, answers it, then takes the next.
// Assumes the bench holds tmpl_i, mode_i and delay_i steady per run.
module equip_model
  import pds_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire req_frame_type req_i,
  input  wire logic          req_valid_i,
  output logic               req_ready_o,
  output rsp_frame_type      rsp_o,
  output logic               rsp_valid_o,
  input  wire rsp_frame_type tmpl_i,
  input  wire logic [1:0]    mode_i,
  input  wire logic [4:0]    delay_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Answer engine
  // Mode 1 mutes, 2 misnumbers, 3 zeroes the number of download request answers
  req_frame_type held;
  rsp_frame_type r;
  logic          dl;
  initial
  begin
    req_ready_o = 1'b0;
    rsp_valid_o = 1'b0;
    rsp_o       = '0;
  end
  always @(posedge ref_clk_i)
  begin
    if (rst_n_i && req_valid_i)
    begin
      repeat (delay_i) @(posedge ref_clk_i);
      req_ready_o <= 1'b1;
      @(posedge ref_clk_i);
      held = req_i;
      dl = held.cmd == CMD_DL_REQ;
      req_ready_o <= 1'b0;
      r = tmpl_i;
      r.cmd = held.cmd | 8'h80;
      r.seq = held.seq;
      r.fseq = !dl || mode_i == 2'h0 ? held.fseq :
               mode_i == 2'h3 ? 8'h00 : ~held.fseq;
      if (!(dl && mode_i == 2'h1))
      begin
        repeat (delay_i) @(posedge ref_clk_i);
        rsp_o       <= r;
        rsp_valid_o <= 1'b1;
        @(posedge ref_clk_i);
        rsp_valid_o <= 1'b0;
        // Stale fields would hide a design that samples late
        rsp_o       <= ~r;
      end
    end
  end
endmodule : equip_model

// ===== sim/program_download_sequencer_test.sv
// Bench: AXI-Lite master, equipment model, queued expectations.
// Assumes a 20-cycle transition wait and a 50-cycle response wait.
module program_download_sequencer_test
  import pds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Signals
  logic          ref_clk_i = 1'b0, rst_n_i = 1'b0, s_axi_awvalid_i = 1'b0;
  logic          s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic          s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0]    s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0]   s_axi_wdata_i = '0;
  logic [3:0]    s_axi_wstrb_i = 4'hF;
  logic [1:0]    mode = '0;
  logic [4:0]    delay = '0;
  rsp_frame_type tmpl = '0;
  logic          s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic          s_axi_arready_o, s_axi_rvalid_o, req_valid_o;
  logic          req_ready_i, rsp_valid_i, error_led_o, discard_o, done_o;
  logic [7:0]    link_speed_o, spd;
  logic [31:0]   s_axi_rdata_o;
  logic [1:0]    s_axi_bresp_o, s_axi_rresp_o;
  logic [23:0]   mfr;
  logic [47:0]   pid, e, m;
  logic [33:0]   ax_q[$];
  logic [47:0]   fr_q[$];
  req_frame_type req_o;
  rsp_frame_type rsp_i;
  int            errors, total_checks, tnum, disc;
  program_download_sequencer #(.TRANS_CYCLES(20), .WAIT_CYCLES(50))
    program_download_sequencer_i (.ref_clk_i, .rst_n_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .req_o, .req_valid_o, .req_ready_i, .rsp_i, .rsp_valid_i,
    .link_speed_o, .error_led_o, .discard_o, .done_o);
  equip_model equip_model_i (.ref_clk_i, .rst_n_i, .req_i(req_o),
    .req_valid_i(req_valid_o), .req_ready_o(req_ready_i), .rsp_o(rsp_i),
    .rsp_valid_o(rsp_valid_i), .tmpl_i(tmpl), .mode_i(mode),
    .delay_i(delay));
  always #25 ref_clk_i = ~ref_clk_i;
  // ====================
  // Checking
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic hang();
    errors++;
    report_and_stop();
  endtask : hang
  // Frames compare only the fields that their command defines
  always @(posedge ref_clk_i)
  begin
    if (rst_n_i && s_axi_rvalid_o && s_axi_rready_i)
      check({s_axi_rresp_o, s_axi_rdata_o}, ax_q.pop_front());
    if (rst_n_i && s_axi_bvalid_o && s_axi_bready_i)
      check({s_axi_bresp_o, 32'h0}, ax_q.pop_front());
    if (rst_n_i && discard_o)
      disc++;
    if (rst_n_i && req_valid_o && req_ready_i)
    begin
      e = fr_q.pop_front();
      m = e[47:40] == CMD_DL_REQ ? 48'hFFFFFFFFFF00 :
          e[47:40] == CMD_DONE_NOTIFY ? 48'hFFFFFF0000FF : 48'hFF00000000FF;
      check({req_o.start, req_o.ftype}, {FRAME_START, FRAME_TYPE});
      check({req_o.cmd, req_o.len, req_o.seq, req_o.result} & m,
            e & m);
    end
  end
  // ====================
  // Drivers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int n;
    ax_q.push_back({r, 32'h0});
    // Let an edge pass so the previous call's releases have landed
    @(posedge ref_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      n++;
    end
    while (n < 99 && !s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    if (!s_axi_bvalid_o) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] x);
    int n;
    ax_q.push_back(x);
    @(posedge ref_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      n++;
    end
    while (n < 99 && !s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    if (!s_axi_rvalid_o) hang();
  endtask : axi_rd
  task automatic note(input logic [7:0] c, input logic [15:0] s,
                      input logic [7:0] r);
    fr_q.push_back({c, (c == CMD_DONE_NOTIFY) ? LEN_DONE : LEN_DL_REQ, s, r});
  endtask : note
  task automatic run(input logic [3:0] c, input logic ee, input int ed);
    int n, g;
    disc = 0;
    axi_wr(OFS_CTRL, {28'h0, c}, RESP_OKAY);
    for (g = 0; g < 99 && !req_valid_o; g++) @(posedge ref_clk_i);
    for (n = 0; n < 3000 && !done_o; n++) @(posedge ref_clk_i);
    if (!done_o) hang();
    check(g >= 17, c[1] && c[2]);
    check(error_led_o, ee);
    check(disc, ed);
    check(fr_q.size(), 0);
    $display("test %0d done", tnum++);
  endtask : run
  // Runs 0-3 vary the answers, 4-5 fetch data, 6-8 must fail
  task automatic scen(input int k);
    int   i, nd;
    logic ok;
    ok = k == 0 || k == 3 || k == 4 || k == 5;
    mode = (k < 4) ? k[1:0] : 2'h0;
    delay = 5'($urandom_range(0, 20));
    tmpl.pid = pid ^ 48'(k == 4 || k == 5 || k == 8);
    tmpl.mfr = mfr ^ 24'(k == 7);
    if (k == 6) axi_wr(OFS_ENV, 32'h05, RESP_OKAY);
    if (k == 8) axi_wr(OFS_MAXSIZE, 32'(tmpl.data_len), RESP_OKAY);
    if (k == 5) note(CMD_VALIDATE, 16'h0, VALID_CUR_SPEED);
    nd = (k == 7) ? 1 : (k == 4 || k == 5 || k == 8) ? 4 : 2;
    for (i = 0; i < ((k == 1 || k == 2) ? 4 : nd); i++)
      note(CMD_DL_REQ, (k == 1 || k == 2) ? 16'h0 : 16'(i), 8'h0);
    note(CMD_DONE_NOTIFY, 16'h0, ok ? RESULT_OK : RESULT_FAIL);
    run((k == 5) ? 4'hF : (k == 4) ? 4'h7 : (k == 3) ? 4'h3 : 4'h1, !ok,
        int'(k >= 6));
    if (k == 6) axi_wr(OFS_ENV, 32'h0, RESP_OKAY);
  endtask : scen
  initial
  begin
    int k;
    void'($urandom(99191));
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    axi_rd(OFS_ENV, {RESP_OKAY, 24'h0, ENV_INTERP});
    axi_rd(OFS_MAXSIZE, {RESP_OKAY, 16'h0, MAXSIZE_RESET});
    axi_rd(8'h40, {RESP_SLVERR, 32'h0});
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    mfr = 24'($urandom);
    pid = {16'($urandom), $urandom};
    spd = 8'($urandom);
    axi_wr(OFS_MFR, {8'h0, mfr}, RESP_OKAY);
    axi_wr(OFS_PID_LO, pid[31:0], RESP_OKAY);
    axi_wr(OFS_PID_HI, {16'h0, pid[47:32]}, RESP_OKAY);
    axi_wr(OFS_SPEED, {24'h0, spd}, RESP_OKAY);
    check(link_speed_o, spd);
    tmpl.check_ok = 1'b1;
    tmpl.split_cnt = 16'h2;
    tmpl.env_id = ENV_INTERP;
    tmpl.data_len = 8'($urandom_range(1, 128));
    for (k = 0; k < 9; k++)
      scen(k);
    axi_rd(OFS_CTRL, {RESP_OKAY, 32'h0});
    report_and_stop();
  end
endmodule : program_download_sequencer_test
